// >>> alusa_pkg.sv
// Shared constants and types for the ALU status and operand addressing block
package alusa_pkg;

  // Flag register layout
  localparam int FLAG_C_POS     = 0;
  localparam int FLAG_NC_POS    = 1;
  localparam int FLAG_Z_POS     = 2;
  localparam int FLAG_OV_POS    = 3;
  localparam int FLAG_N_POS     = 4;
  localparam int FLAG_WIDTH     = 5;
  localparam logic [4:0] FLAGS_RESET = 5'h00;

  // Data memory address of the flag register (12-bit linear space)
  localparam logic [11:0] ALU_FLAGS_ADDR = 12'hFD8;
  // Access bank split: low part maps to bank 0, upper part to bank F
  localparam logic [7:0]  ACCESS_SPLIT   = 8'h60;
  localparam logic [3:0]  ACCESS_HI_BANK = 4'hF;
  // Largest literal offset for indexed mode
  localparam logic [7:0]  INDEX_MAX      = 8'h5F;

  // Register port map (word offsets)
  localparam logic [3:0] REG_FLAGS     = 4'h0;
  localparam logic [3:0] REG_BANK      = 4'h1;
  localparam logic [3:0] REG_WREG      = 4'h2;
  localparam logic [3:0] REG_PTR_LO    = 4'h3;
  localparam logic [3:0] REG_PTR_HI    = 4'h4;
  localparam logic [3:0] REG_LAST_ADDR = 4'h5;
  localparam logic [3:0] REG_LAST_RES  = 4'h6;

  // Operations presented by the decoder
  typedef enum logic [4:0] {
    ALUSA_NOP,
    ALUSA_ADD_WREG_FILE,
    ALUSA_ADD_LITERAL,
    ALUSA_SUB_FROM_LITERAL,
    ALUSA_SUB_WREG_FROM_FILE,
    ALUSA_LOAD_LITERAL,
    ALUSA_CLEAR_FILE,
    ALUSA_BIT_CLEAR,
    ALUSA_BIT_SET,
    ALUSA_NIBBLE_SWAP,
    ALUSA_FILE_TO_FILE_MOVE,
    ALUSA_WREG_TO_FILE,
    ALUSA_AND_WREG_FILE,
    ALUSA_IOR_WREG_FILE,
    ALUSA_XOR_WREG_FILE,
    ALUSA_MOVE_FILE,
    ALUSA_DECIMAL_ADJUST,
    ALUSA_SLEEP,
    ALUSA_RESET,
    ALUSA_CALL,
    ALUSA_JUMP
  } alusa_op_t;

  // Execution sequencer states
  typedef enum logic [0:0] {
    ALUSA_IDLE,
    ALUSA_HALT
  } alusa_state_t;

endpackage : alusa_pkg

// >>> alusa_core.sv
// ALU flag generation, operand address resolution and result routing
//
// Decided for this implementation: the plain strobed port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - Flag register is an ordinary operand, readable and writable like other registers.
// - Flag-affecting op aimed at flag register drops result, only flags update.
// - Clearing flag register sets zero flag, keeps other flag bits.
// - Bit clear/set, swap, working-register and file-to-file moves leave all five flags untouched unless the flag register is their target.
// - In subtraction carry and nibble carry mean not-borrow.
// - Negative flag bit 4 equals result bit 7.
// - Overflow flag bit 3 set on signed overflow of the result.
// - Zero flag bit 2 set when result is zero, else cleared.
// - Nibble carry bit 1 is carry out of result bit 3 for add/sub.
// - Carry bit 0 is carry out of result bit 7 for add/sub.
// - Inherent ops use no operand field, act globally or on implied register.
// - Literal ops take constant from opcode; call/jump carry 20-bit target.
// - File ops take the 8-bit address from the opcode low byte.
// - Bank bit 1 joins bank select with the 8-bit address.
// - Bank bit 0 maps the 8-bit address into the access bank.
// - Full 12-bit address ops use it directly, bank select ignored.
// - Destination bit 1 writes back to file, 0 writes working register.
// - Ops without destination bit write a fixed implied location.
// - Indexed literal-offset mode only with extended ops enabled.
// - Extended, access bank, address up to 5Fh: offset from third pointer pair.
module alusa_core
  import alusa_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              reset_n,
  input  wire logic              extended_ops_enable,
  input  wire logic              instr_valid,
  input  wire alusa_pkg::alusa_op_t instr_op,
  input  wire logic [15:0]       instr_word,
  input  wire logic [11:0]       full_addr,
  input  wire logic [7:0]        file_data,
  input  wire logic [3:0]        reg_addr,
  input  wire logic [7:0]        reg_wdata,
  input  wire logic              reg_write,
  input  wire logic              reg_read,
  output logic [7:0]             reg_rdata,
  output logic [11:0]            mem_addr,
  output logic [7:0]             mem_wdata,
  output logic                   mem_write,
  output logic [7:0]             wreg,
  output logic [4:0]             alu_flags,
  output logic [19:0]            jump_target,
  output logic                   jump_valid,
  output logic                   sleep_req,
  output logic                   soft_reset_req
);
  import alusa_pkg::*;

  // Decoded opcode fields
  logic [7:0]  lit;
  logic        dest_bit;
  logic        bank_bit;
  logic [2:0]  bit_sel;
  logic [3:0]  bank_select;
  logic [11:0] third_pointer_pair;
  logic [11:0] next_addr;
  logic [8:0]  sum;
  logic [4:0]  nib;
  logic [7:0]  opa;
  logic [7:0]  opb;
  logic        is_arith;
  logic        sets_zn;
  logic        to_file;
  logic        to_wreg;
  logic        writes_any;
  logic [7:0]  result;
  logic [4:0]  next_flags;
  logic        flag_target;
  logic [11:0] last_addr;
  logic [7:0]  last_result;
  alusa_state_t state;

  assign lit      = instr_word[7:0];
  assign dest_bit = instr_word[9];
  assign bank_bit = instr_word[8];
  assign bit_sel  = instr_word[11:9];

  // Operand address resolution, full-address ops first
  function automatic logic [11:0] resolve_addr(input logic full, input logic [11:0] faddr,
                                              input logic a, input logic [7:0] f,
                                              input logic [3:0] bsel, input logic ext,
                                              input logic [11:0] ptr);
    logic [11:0] r;
    r = 12'h000;
    if (full)
      r = faddr;
    else if (a)
      r = {bsel, f};
    else if (ext && (f <= INDEX_MAX))
      r = ptr + {4'h0, f};
    else if (f < ACCESS_SPLIT)
      r = {4'h0, f};
    else
      r = {ACCESS_HI_BANK, f};
    return r;
  endfunction : resolve_addr

  assign next_addr = resolve_addr(instr_op == ALUSA_FILE_TO_FILE_MOVE, full_addr, bank_bit, lit,
                                  bank_select, extended_ops_enable, third_pointer_pair);
  assign flag_target = (next_addr == ALU_FLAGS_ADDR);

  // Operand read sees the flag register when it is the source
  assign opb = flag_target ? {3'h0, alu_flags} : file_data;

  // Datapath result and flag candidates
  always_comb
  begin
    opa        = wreg;
    sum        = 9'h000;
    nib        = 5'h00;
    result     = 8'h00;
    is_arith   = 1'b0;
    sets_zn    = 1'b0;
    to_file    = 1'b0;
    to_wreg    = 1'b0;
    case (instr_op)
      ALUSA_ADD_WREG_FILE, ALUSA_ADD_LITERAL:
      begin
        opa      = (instr_op == ALUSA_ADD_LITERAL) ? lit : opb;
        sum      = {1'b0, wreg} + {1'b0, opa};
        nib      = {1'b0, wreg[3:0]} + {1'b0, opa[3:0]};
        result   = sum[7:0];
        is_arith = 1'b1;
        sets_zn  = 1'b1;
        to_file  = (instr_op == ALUSA_ADD_WREG_FILE) && dest_bit;
        to_wreg  = !to_file;
      end
      ALUSA_SUB_FROM_LITERAL, ALUSA_SUB_WREG_FROM_FILE:
      begin
        opa      = (instr_op == ALUSA_SUB_FROM_LITERAL) ? lit : opb;
        sum      = {1'b0, opa} + {1'b0, ~wreg} + 9'h001;
        nib      = {1'b0, opa[3:0]} + {1'b0, ~wreg[3:0]} + 5'h01;
        result   = sum[7:0];
        is_arith = 1'b1;
        sets_zn  = 1'b1;
        to_file  = (instr_op == ALUSA_SUB_WREG_FROM_FILE) && dest_bit;
        to_wreg  = !to_file;
      end
      ALUSA_AND_WREG_FILE, ALUSA_IOR_WREG_FILE, ALUSA_XOR_WREG_FILE, ALUSA_MOVE_FILE:
      begin
        case (instr_op)
          ALUSA_AND_WREG_FILE: result = wreg & opb;
          ALUSA_IOR_WREG_FILE: result = wreg | opb;
          ALUSA_XOR_WREG_FILE: result = wreg ^ opb;
          default:             result = opb;
        endcase
        sets_zn = 1'b1;
        to_file = dest_bit;
        to_wreg = !dest_bit;
      end
      ALUSA_CLEAR_FILE:
      begin
        result  = 8'h00;
        sets_zn = 1'b1;
        to_file = 1'b1;
      end
      ALUSA_NIBBLE_SWAP:
      begin
        result  = {opb[3:0], opb[7:4]};
        to_file = dest_bit;
        to_wreg = !dest_bit;
      end
      ALUSA_BIT_CLEAR:
      begin
        result  = opb & ~(8'h01 << bit_sel);
        to_file = 1'b1;
      end
      ALUSA_BIT_SET:
      begin
        result  = opb | (8'h01 << bit_sel);
        to_file = 1'b1;
      end
      ALUSA_WREG_TO_FILE:
      begin
        result  = wreg;
        to_file = 1'b1;
      end
      ALUSA_FILE_TO_FILE_MOVE:
      begin
        result  = file_data;
        to_file = 1'b1;
      end
      ALUSA_LOAD_LITERAL:
      begin
        result  = lit;
        to_wreg = 1'b1;
      end
      ALUSA_DECIMAL_ADJUST:
      begin
        // Implied working register, no operand field
        opa = wreg;
        if (wreg[3:0] > 4'h9 || alu_flags[FLAG_NC_POS])
          opa = opa + 8'h06;
        sum = {1'b0, opa};
        if (opa[7:4] > 4'h9 || alu_flags[FLAG_C_POS])
          sum = {1'b0, opa} + 9'h060;
        result  = sum[7:0];
        to_wreg = 1'b1;
      end
      default:
      begin
        result = 8'h00;
      end
    endcase
  end

  assign writes_any = to_file || to_wreg;

  // Next flag value: arithmetic sets all five, logic sets zero and negative
  always_comb
  begin
    next_flags = alu_flags;
    if (is_arith)
    begin
      next_flags[FLAG_C_POS]  = sum[8];
      next_flags[FLAG_NC_POS] = nib[4];
      next_flags[FLAG_OV_POS] = (opa[7] == (instr_op inside {ALUSA_ADD_WREG_FILE, ALUSA_ADD_LITERAL}
                                ? wreg[7] : ~wreg[7])) && (result[7] != opa[7]);
    end
    if (sets_zn)
    begin
      next_flags[FLAG_Z_POS] = (result == 8'h00);
      // Clear moves only Z, so N keeps its old value
      if (instr_op != ALUSA_CLEAR_FILE)
        next_flags[FLAG_N_POS] = result[7];
    end
    if (instr_op == ALUSA_DECIMAL_ADJUST)
      next_flags[FLAG_C_POS] = sum[8] | alu_flags[FLAG_C_POS];
  end

  // Flags: flag-affecting op on flag register keeps only flag updates
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      alu_flags <= FLAGS_RESET;
    else if (reg_write && reg_addr == REG_FLAGS)
      alu_flags <= reg_wdata[4:0];
    else if (instr_valid && state == ALUSA_IDLE)
    begin
      if (to_file && flag_target && !(is_arith || sets_zn))
        alu_flags <= result[4:0];
      else
        alu_flags <= next_flags;
    end
  end

  // Working register write-back, same edge as the flags
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      wreg <= 8'h00;
    else if (reg_write && reg_addr == REG_WREG)
      wreg <= reg_wdata;
    else if (instr_valid && state == ALUSA_IDLE && to_wreg)
      wreg <= result;
  end

  // Data memory write port, suppressed when the flag register is target
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      mem_addr  <= 12'h000;
      mem_wdata <= 8'h00;
      mem_write <= 1'b0;
    end
    else
    begin
      mem_addr  <= next_addr;
      mem_wdata <= result;
      mem_write <= instr_valid && state == ALUSA_IDLE && to_file && !flag_target;
    end
  end

  // Bookkeeping of last resolved address and result for software
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      last_addr   <= 12'h000;
      last_result <= 8'h00;
    end
    else if (instr_valid && state == ALUSA_IDLE && writes_any)
    begin
      last_addr   <= next_addr;
      last_result <= result;
    end
  end

  // Inherent and program-flow requests
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      jump_target    <= 20'h00000;
      jump_valid     <= 1'b0;
      sleep_req      <= 1'b0;
      soft_reset_req <= 1'b0;
    end
    else
    begin
      jump_valid     <= instr_valid && state == ALUSA_IDLE &&
                        (instr_op == ALUSA_CALL || instr_op == ALUSA_JUMP);
      jump_target    <= {full_addr, lit};
      sleep_req      <= instr_valid && state == ALUSA_IDLE && instr_op == ALUSA_SLEEP;
      soft_reset_req <= instr_valid && state == ALUSA_IDLE && instr_op == ALUSA_RESET;
    end
  end

  // Sleep halts execution until software writes the bank register
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      state <= ALUSA_IDLE;
    else
      case (state)
        ALUSA_IDLE: if (instr_valid && instr_op == ALUSA_SLEEP) state <= ALUSA_HALT;
        ALUSA_HALT: if (reg_write && reg_addr == REG_BANK) state <= ALUSA_IDLE;
        default:    state <= ALUSA_IDLE;
      endcase
  end

  // Bank select and pointer registers written by software
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      bank_select        <= 4'h0;
      third_pointer_pair <= 12'h000;
    end
    else if (reg_write)
      case (reg_addr)
        REG_BANK:   bank_select <= reg_wdata[3:0];
        REG_PTR_LO: third_pointer_pair[7:0] <= reg_wdata;
        REG_PTR_HI: third_pointer_pair[11:8] <= reg_wdata[3:0];
        default:    bank_select <= bank_select;
      endcase
  end

  // Read port, data one cycle after the strobe, unused bits zero
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      reg_rdata <= 8'h00;
    else if (reg_read)
      case (reg_addr)
        REG_FLAGS:     reg_rdata <= {3'h0, alu_flags};
        REG_BANK:      reg_rdata <= {4'h0, bank_select};
        REG_WREG:      reg_rdata <= wreg;
        REG_PTR_LO:    reg_rdata <= third_pointer_pair[7:0];
        REG_PTR_HI:    reg_rdata <= {4'h0, third_pointer_pair[11:8]};
        REG_LAST_ADDR: reg_rdata <= last_addr[7:0];
        REG_LAST_RES:  reg_rdata <= last_result;
        default:       reg_rdata <= 8'h00;
      endcase
    else
      reg_rdata <= 8'h00;
  end

  logic exec;
  assign exec = instr_valid && state == ALUSA_IDLE && !(reg_write && reg_addr == REG_FLAGS);

  zero_flag_a: assert property (@(posedge clk) disable iff (!reset_n)
    exec && sets_zn |=> alu_flags[FLAG_Z_POS] == ($past(result) == 8'h00)) else $error("zero flag wrong");
  neg_flag_a: assert property (@(posedge clk) disable iff (!reset_n)
    exec && sets_zn && instr_op != ALUSA_CLEAR_FILE
    |=> alu_flags[FLAG_N_POS] == $past(result[7])) else $error("negative flag wrong");
  carry_flag_a: assert property (@(posedge clk) disable iff (!reset_n)
    exec && is_arith |=> alu_flags[FLAG_C_POS] == $past(sum[8])) else $error("carry flag wrong");
  nib_flag_a: assert property (@(posedge clk) disable iff (!reset_n)
    exec && is_arith |=> alu_flags[FLAG_NC_POS] == $past(nib[4])) else $error("nibble carry wrong");
  flag_drop_a: assert property (@(posedge clk) disable iff (!reset_n)
    exec && flag_target && (is_arith || sets_zn) |=> !mem_write) else $error("result written to flags");
  clear_flags_a: assert property (@(posedge clk) disable iff (!reset_n)
    exec && instr_op == ALUSA_CLEAR_FILE && flag_target
    |=> alu_flags == ($past(alu_flags) | 5'h04)) else $error("clear flags pattern wrong");
  keep_flags_a: assert property (@(posedge clk) disable iff (!reset_n)
    exec && !flag_target && instr_op inside {ALUSA_BIT_SET, ALUSA_BIT_CLEAR, ALUSA_NIBBLE_SWAP,
    ALUSA_WREG_TO_FILE, ALUSA_FILE_TO_FILE_MOVE} |=> $stable(alu_flags)) else $error("flags disturbed");
  bank_addr_a: assert property (@(posedge clk) disable iff (!reset_n)
    exec && bank_bit && instr_op != ALUSA_FILE_TO_FILE_MOVE
    |=> mem_addr == {$past(bank_select), $past(lit)}) else $error("banked address wrong");
  full_addr_a: assert property (@(posedge clk) disable iff (!reset_n)
    exec && instr_op == ALUSA_FILE_TO_FILE_MOVE |=> mem_addr == $past(full_addr)) else $error("full address wrong");
  dest_wreg_a: assert property (@(posedge clk) disable iff (!reset_n)
    exec && to_wreg && !(reg_write && reg_addr == REG_WREG) |=> wreg == $past(result)) else $error("wreg not written");

endmodule : alusa_core
`default_nettype wire

// >>> alusa_mem_model.sv
// Behavioural banked data memory standing beside the ALU block
`timescale 1ns/100ps
`default_nettype none
module alusa_mem_model
  import alusa_pkg::*;
(
  input  wire logic        clk,
  input  wire logic [11:0] rd_addr,
  input  wire logic [4:0]  flags,
  input  wire logic [11:0] mem_addr,
  input  wire logic [7:0]  mem_wdata,
  input  wire logic        mem_write,
  output logic [7:0]       file_data
);
  logic [7:0] mem [0:4095];

  // Known fill, so expected operands follow from the address alone
  initial
  begin
    for (int i = 0; i < 4096; i++)
      mem[i] = 8'(i) ^ 8'h5A;
  end

  // Flag register is mapped like any other register, read straight from the core
  assign file_data = (rd_addr == ALU_FLAGS_ADDR) ? {3'h0, flags} : mem[rd_addr];

  // Write-back lands at the edge that sees the pulse
  always @(posedge clk)
  begin
    if (mem_write)
      mem[mem_addr] <= mem_wdata;
  end
endmodule : alusa_mem_model
`default_nettype wire

// >>> alusa_core_tb_top.sv
// Self-checking testbench for the ALU flag and operand addressing block
`timescale 1ns/100ps
`default_nettype none
module alusa_core_tb_top;
  import alusa_pkg::*;
  logic        clk, reset_n, extended_ops_enable, instr_valid, reg_write, reg_read;
  alusa_op_t   instr_op;
  logic [15:0] instr_word;
  logic [11:0] full_addr, rd_addr, mem_addr, ptr;
  logic [7:0]  file_data, reg_wdata, reg_rdata, mem_wdata, wreg, w;
  logic [3:0]  reg_addr, bank;
  logic        mem_write, jump_valid, sleep_req, soft_reset_req, xs;
  logic [4:0]  alu_flags, fl;
  logic [19:0] jump_target;
  int          bad_count = 0;
  int          n_compared = 0;

  alusa_core u_alusa_core (.clk(clk), .reset_n(reset_n), .extended_ops_enable(extended_ops_enable),
    .instr_valid(instr_valid), .instr_op(instr_op), .instr_word(instr_word), .full_addr(full_addr),
    .file_data(file_data), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_write(mem_write), .wreg(wreg), .alu_flags(alu_flags), .jump_target(jump_target),
    .jump_valid(jump_valid), .sleep_req(sleep_req), .soft_reset_req(soft_reset_req));

  alusa_mem_model u_alusa_mem_model (.clk(clk), .rd_addr(rd_addr), .flags(alu_flags),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_write(mem_write), .file_data(file_data));

  // 100 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic end_sim;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : end_sim

  task automatic chk(input logic [19:0] got, input logic [19:0] exp, input string what);
    n_compared++;
    if (got !== exp)
    begin
      bad_count++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  // Fill pattern of the memory model
  function automatic logic [7:0] pat(input logic [11:0] ad);
    return ad[7:0] ^ 8'h5A;
  endfunction : pat

  // Returns {N, OV, Z, NC, C, result}; subtraction adds the inverse plus one
  function automatic logic [12:0] alu(input logic [7:0] x, input logic [7:0] y, input logic sub);
    logic [7:0] yy;
    logic [8:0] s;
    logic [4:0] h;
    yy = sub ? ~y : y;
    s = {1'b0, x} + {1'b0, yy} + 9'(sub);
    h = {1'b0, x[3:0]} + {1'b0, yy[3:0]} + 5'(sub);
    return {s[7], (x[7] == yy[7]) && (s[7] != x[7]), s[7:0] == 8'h00, h[4], s[8], s[7:0]};
  endfunction : alu

  function automatic logic [11:0] res_addr(input logic a, input logic [7:0] lit);
    if (a)
      return {bank, lit};
    if (xs && lit <= INDEX_MAX)
      return ptr + 12'(lit);
    return (lit < ACCESS_SPLIT) ? {4'h0, lit} : {ACCESS_HI_BANK, lit};
  endfunction : res_addr

  task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_write <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_read <= 1'b0;
    #1;
    chk(reg_rdata, exp, "register read");
  endtask : reg_rd

  // One instruction; returns just after the edge that takes it
  task automatic exec(input alusa_op_t op, input logic [15:0] wd, input logic [11:0] fa, input logic [11:0] ra);
    @(posedge clk);
    instr_valid <= 1'b1;
    instr_op    <= op;
    instr_word  <= wd;
    full_addr   <= fa;
    rd_addr     <= ra;
    @(posedge clk);
    instr_valid <= 1'b0;
    #1;
  endtask : exec

  task automatic do_arith(input alusa_op_t op, input logic a, input logic d, input logic [7:0] lit);
    logic [11:0] ad;
    logic [7:0]  f;
    logic [12:0] res;
    logic        fop;
    logic        wr;
    ad = res_addr(a, lit);
    f = (ad == ALU_FLAGS_ADDR) ? {3'h0, fl} : pat(ad);
    fop = (op == ALUSA_ADD_WREG_FILE) || (op == ALUSA_SUB_WREG_FROM_FILE);
    case (op)
      ALUSA_ADD_WREG_FILE:      res = alu(f, w, 1'b0);
      ALUSA_SUB_WREG_FROM_FILE: res = alu(f, w, 1'b1);
      ALUSA_ADD_LITERAL:        res = alu(lit, w, 1'b0);
      ALUSA_SUB_FROM_LITERAL:   res = alu(lit, w, 1'b1);
      default:                  res = {fl, lit};
    endcase
    wr = fop && d && (ad != ALU_FLAGS_ADDR);
    if (!(fop && d))
      w = res[7:0];
    fl = res[12:8];
    exec(op, {6'h0, d, a, lit}, 12'h000, ad);
    chk(mem_write, wr, "write strobe");
    if (wr)
    begin
      chk(mem_addr, ad, "write address");
      chk(mem_wdata, res[7:0], "write data");
    end
    chk(wreg, w, "working register");
    chk(alu_flags, fl, "flags");
  endtask : do_arith

  // Write-back without flag effects beyond those already in the shadow
  task automatic file_wr(input alusa_op_t op, input logic [15:0] wd, input logic [11:0] ad, input logic [7:0] d);
    // Full address doubles as the file-to-file move's own address
    exec(op, wd, ad, ad);
    chk(mem_write, 1'b1, "write strobe");
    chk(mem_addr, ad, "write address");
    chk(mem_wdata, d, "write data");
    chk(alu_flags, fl, "flags");
    chk(wreg, w, "working register");
  endtask : file_wr

  // Hang guard
  initial
  begin
    repeat (20000) @(posedge clk);
    bad_count++;
    $display("MISMATCH at %0t: run timed out", $time);
    end_sim();
  end

  // Main sequence
  initial
  begin
    {reset_n, extended_ops_enable, instr_valid, reg_write, reg_read, xs} = '0;
    instr_op = ALUSA_NOP;
    {instr_word, full_addr, rd_addr, reg_wdata, reg_addr} = '0;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    reg_rd(REG_FLAGS, 8'h00);
    reg_wr(REG_FLAGS, 8'hFF);
    fl = 5'h1F;
    reg_rd(REG_FLAGS, 8'h1F);
    reg_rd(4'hF, 8'h00);
    bank = 4'h3;
    reg_wr(REG_BANK, {4'h0, bank});
    reg_rd(REG_BANK, 8'h03);
    w = 8'h7F;
    reg_wr(REG_WREG, w);
    do_arith(ALUSA_ADD_WREG_FILE, 1'b1, 1'b1, 8'h10);
    do_arith(ALUSA_ADD_WREG_FILE, 1'b0, 1'b0, 8'h70);
    do_arith(ALUSA_SUB_WREG_FROM_FILE, 1'b0, 1'b1, 8'h20);
    do_arith(ALUSA_ADD_LITERAL, 1'b0, 1'b0, 8'h57);
    do_arith(ALUSA_LOAD_LITERAL, 1'b0, 1'b0, 8'h80);
    do_arith(ALUSA_SUB_FROM_LITERAL, 1'b0, 1'b0, 8'h80);
    do_arith(ALUSA_LOAD_LITERAL, 1'b0, 1'b0, 8'h88);
    do_arith(ALUSA_ADD_LITERAL, 1'b0, 1'b0, 8'h88);
    do_arith(ALUSA_ADD_WREG_FILE, 1'b0, 1'b1, 8'hD8);
    file_wr(ALUSA_BIT_SET, {4'h0, 3'h5, 1'b1, 8'h40}, 12'h340, 8'h3A);
    file_wr(ALUSA_BIT_CLEAR, {4'h0, 3'h1, 1'b1, 8'h41}, 12'h341, 8'h19);
    file_wr(ALUSA_NIBBLE_SWAP, {6'h0, 1'b1, 1'b1, 8'h42}, 12'h342, 8'h81);
    file_wr(ALUSA_WREG_TO_FILE, {7'h0, 1'b1, 8'h43}, 12'h343, w);
    file_wr(ALUSA_FILE_TO_FILE_MOVE, 16'h0000, 12'h2A5, 8'hFF);
    // Clear of the flag register with N high: N must survive
    reg_wr(REG_FLAGS, 8'h1B);
    exec(ALUSA_CLEAR_FILE, {6'h0, 1'b1, 1'b0, 8'hD8}, 12'h000, ALU_FLAGS_ADDR);
    chk(mem_write, 1'b0, "write strobe");
    chk(alu_flags, 5'h1F, "flags after clear");
    // Bit clear aimed at the flag register lands in the flags
    exec(ALUSA_BIT_CLEAR, {4'h0, 3'h0, 1'b0, 8'hD8}, 12'h000, ALU_FLAGS_ADDR);
    chk(mem_write, 1'b0, "write strobe");
    chk(alu_flags, 5'h1E, "flags after bit clear");
    fl = 5'h1E;
    // Indexed mode only with extended ops on
    @(posedge clk);
    xs = 1'b1;
    extended_ops_enable <= xs;
    reg_wr(REG_PTR_LO, 8'h23);
    reg_wr(REG_PTR_HI, 8'h01);
    ptr = 12'h123;
    reg_rd(REG_PTR_HI, 8'h01);
    do_arith(ALUSA_ADD_WREG_FILE, 1'b0, 1'b1, 8'h05);
    do_arith(ALUSA_ADD_WREG_FILE, 1'b0, 1'b1, 8'h60);
    do_arith(ALUSA_ADD_WREG_FILE, 1'b1, 1'b1, 8'h05);
    @(posedge clk);
    xs = 1'b0;
    extended_ops_enable <= xs;
    do_arith(ALUSA_ADD_WREG_FILE, 1'b0, 1'b1, 8'h06);
    // Program targets, then the one-cycle pulse drops
    for (int k = 0; k < 2; k++)
    begin
      exec(k ? ALUSA_JUMP : ALUSA_CALL, {8'h0, 8'h34}, 12'hABC, 12'h000);
      chk(jump_valid, 1'b1, "target strobe");
      chk(jump_target, 20'hABC34, "target");
      @(posedge clk);
      #1;
      chk(jump_valid, 1'b0, "target strobe end");
    end
    exec(ALUSA_RESET, 16'h0000, 12'h000, 12'h000);
    chk(soft_reset_req, 1'b1, "reset request");
    exec(ALUSA_SLEEP, 16'h0000, 12'h000, 12'h000);
    chk(sleep_req, 1'b1, "sleep request");
    exec(ALUSA_ADD_LITERAL, 16'h0011, 12'h000, 12'h000);
    chk(wreg, w, "ignored while halted");
    reg_wr(REG_BANK, {4'h0, bank});
    do_arith(ALUSA_ADD_LITERAL, 1'b0, 1'b0, 8'h11);
    // Logic op into the working register, then the bookkeeping reads
    w = 8'h0A;
    reg_wr(REG_WREG, w);
    exec(ALUSA_XOR_WREG_FILE, {6'h0, 1'b0, 1'b1, 8'h50}, 12'h000, 12'h350);
    fl[FLAG_Z_POS] = 1'b1;
    fl[FLAG_N_POS] = 1'b0;
    chk(mem_write, 1'b0, "logic write strobe");
    chk(wreg, 8'h00, "logic result");
    chk(alu_flags, fl, "logic flags");
    reg_rd(REG_LAST_ADDR, 8'h50);
    reg_rd(REG_LAST_RES, 8'h00);
    // Decimal adjust works on the implied working register
    reg_wr(REG_FLAGS, 8'h00);
    reg_wr(REG_WREG, 8'h9B);
    exec(ALUSA_DECIMAL_ADJUST, 16'h0000, 12'h000, 12'h000);
    chk(wreg, 8'h01, "decimal adjust");
    chk(alu_flags, 5'h01, "decimal adjust carry");
    end_sim();
  end
endmodule : alusa_core_tb_top
`default_nettype wire
